/* File: core/vie_map.svh */
// Purpose: Register offsets, field positions and constants of the enhancer.
// Assumes: Index addresses are eight bits wide.
// Notes:   Read-write bytes sit in a small array, the polarity byte apart; status reads are separate.
`ifndef VIE_MAP_SVH
`define VIE_MAP_SVH
`define VIE_NREG      32
`define VIE_XW        12
`define VIE_A_FXS     8'h00
`define VIE_A_FXZ     8'h02
`define VIE_A_EXS     8'h04
`define VIE_A_EXZ     8'h06
`define VIE_A_ESTR    8'h08
`define VIE_A_CSTR    8'h09
`define VIE_A_EDGE    8'h0a
`define VIE_A_PWMC    8'h0b
`define VIE_A_DUTY    8'h0c
`define VIE_A_FMT     8'h0d
`define VIE_A_GAM     8'h10
`define VIE_A_COEF    8'h20
`define VIE_A_ADUTY   8'h21
`define VIE_A_STAT    8'h22
`define VIE_A_POL     8'he1
`define VIE_POL_CK    0
`define VIE_POL_HS    1
`define VIE_POL_VS    2
`define VIE_FMT_SYNC  0
`define VIE_FMT_YFST  1
`define VIE_PWMC_AUTO 0
`define VIE_STAT_OVR  0
`define VIE_POL_RST   8'h00
`define VIE_I2C_ADDR  7'h42
`define VIE_I2C_BITS  4'h8
`define VIE_CODE_FF   8'hff
`define VIE_CODE_H    4
`define VIE_CODE_V    5
`define VIE_BUF_FULL  2'h2
`define VIE_MID       128
`define VIE_BYTE_MAX  255
`define VIE_STR_SH    4
`define VIE_CG_SH     6
`define VIE_GAM_SH    5
`define VIE_GAM_FR    31
`define VIE_AVG_SH    6
`endif

/* File: core/vie_pkg.sv */
// Purpose: Types shared by the enhancer modules.
// Assumes: Widths come from the constant map.
// Notes:   Each module keeps its state in one of these structs; vie_top keeps its reset synchronizer apart.
`include "vie_map.svh"
package vie_pkg;
  typedef enum logic [6:0] {
    VIE_IDLE = 7'h01,
    VIE_ADDR = 7'h02,
    VIE_ACKA = 7'h04,
    VIE_WDAT = 7'h08,
    VIE_ACKW = 7'h10,
    VIE_RDAT = 7'h20,
    VIE_ACKR = 7'h40
  } vie_i2c_st_t;

  typedef struct packed {
    vie_i2c_st_t st;
    logic        scl_q;
    logic        sda_q;
    logic [7:0]  sh;
    logic [3:0]  bc;
    logic        rw;
    logic        first;
    logic [7:0]  ptr;
    logic        oe;
    logic        wr;
  } vie_i2c_t;

  typedef struct packed {
    logic                         pck_q;
    logic                         cap_v;
    logic [7:0]                   cap_d;
    logic                         cap_hs;
    logic                         cap_vs;
    logic [1:0]                   sy;
    logic                         hb;
    logic                         vb;
    logic                         va_q;
    logic [`VIE_XW-1:0]           x;
    logic [7:0]                   yp;
    logic [15:0]                  avg;
    logic [7:0]                   coef;
    logic                         s1_v;
    logic [7:0]                   s1_d;
    logic                         s1_hs;
    logic                         s1_vs;
    logic [1:0][9:0]              bq;
    logic [1:0]                   bn;
    logic                         oclk;
    logic [7:0]                   od;
    logic                         ohs;
    logic                         ovs;
    logic                         ovr;
    logic [7:0]                   pdiv;
    logic [7:0]                   pcnt;
    logic [7:0]                   duty;
    logic                         pwm;
    logic [`VIE_NREG-1:0][7:0]    regs;
    logic [7:0]                   sync_clock_polarity;
  } vie_core_t;
endpackage

/* File: core/vie_i2c_tgt.sv */
// Purpose: Two-wire register target with automatic sub-address increment.
// Assumes: Bus lines are synchronous to core_clk and far slower than it.
// Notes:   Data line is open drain; oe high pulls it low.
`include "vie_map.svh"
module vie_i2c_tgt (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       addr_sel,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  vie_pkg::vie_i2c_t r_r, r_nxt;
  logic rise, fall, start, stop, hit;

  always_comb begin
    rise  = !r_r.scl_q && scl_in;
    fall  = r_r.scl_q && !scl_in;
    start = r_r.scl_q && scl_in && r_r.sda_q && !sda_in;
    stop  = r_r.scl_q && scl_in && !r_r.sda_q && sda_in;
    hit   = r_r.sh[7:1] == (`VIE_I2C_ADDR | {6'h00, addr_sel});
    r_nxt = r_r;
    r_nxt.scl_q = scl_in;
    r_nxt.sda_q = sda_in;
    r_nxt.wr = 1'b0;
    if (r_r.wr)
      r_nxt.ptr = r_r.ptr + 8'h01;
    if (start) begin
      r_nxt.st = vie_pkg::VIE_ADDR;
      r_nxt.bc = 4'h0;
      r_nxt.oe = 1'b0;
    end else if (stop) begin
      r_nxt.st = vie_pkg::VIE_IDLE;
      r_nxt.oe = 1'b0;
    end else begin
      unique case (r_r.st)
        vie_pkg::VIE_IDLE: begin
        end
        vie_pkg::VIE_ADDR, vie_pkg::VIE_WDAT: begin
          if (rise) begin
            r_nxt.sh = {r_r.sh[6:0], sda_in};
            r_nxt.bc = r_r.bc + 4'h1;
          end else if (fall && r_r.bc == `VIE_I2C_BITS) begin
            r_nxt.oe = 1'b1;
            if (r_r.st == vie_pkg::VIE_WDAT) begin
              r_nxt.st = vie_pkg::VIE_ACKW;
              r_nxt.first = 1'b0;
              if (r_r.first)
                r_nxt.ptr = r_r.sh;
              else
                r_nxt.wr = 1'b1;
            end else if (hit) begin
              r_nxt.st = vie_pkg::VIE_ACKA;
              r_nxt.rw = r_r.sh[0];
              r_nxt.first = 1'b1;
            end else begin
              r_nxt.st = vie_pkg::VIE_IDLE;
              r_nxt.oe = 1'b0;
            end
          end
        end
        vie_pkg::VIE_ACKA, vie_pkg::VIE_ACKW, vie_pkg::VIE_ACKR: begin
          if (fall) begin
            r_nxt.bc = 4'h0;
            r_nxt.oe = 1'b0;
            r_nxt.st = vie_pkg::VIE_WDAT;
            if (r_r.st == vie_pkg::VIE_ACKR && sda_in) begin
              r_nxt.st = vie_pkg::VIE_IDLE;
            end else if (r_r.st != vie_pkg::VIE_ACKW && r_r.rw) begin
              r_nxt.st = vie_pkg::VIE_RDAT;
              r_nxt.sh = {rd_data[6:0], 1'b0};
              r_nxt.oe = !rd_data[7];
              r_nxt.bc = 4'h1;
            end
          end
        end
        vie_pkg::VIE_RDAT: begin
          if (fall) begin
            if (r_r.bc == `VIE_I2C_BITS) begin
              r_nxt.st = vie_pkg::VIE_ACKR;
              r_nxt.oe = 1'b0;
              r_nxt.ptr = r_r.ptr + 8'h01;
            end else begin
              r_nxt.oe = !r_r.sh[7];
              r_nxt.sh = {r_r.sh[6:0], 1'b0};
              r_nxt.bc = r_r.bc + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
      r_r.st <= vie_pkg::VIE_IDLE;
      r_r.scl_q <= 1'b1;
      r_r.sda_q <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = r_r.oe;
  assign wr_en   = r_r.wr;
  assign wr_addr = r_r.ptr;
  assign wr_data = r_r.sh;
  assign rd_addr = r_r.ptr;

  property p_addr_ack;
    @(posedge core_clk) disable iff (!rst_n)
      (r_r.st == vie_pkg::VIE_ADDR && fall && r_r.bc == `VIE_I2C_BITS
       && !start && !stop) |=> (sda_oe == $past(hit));
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("Address acknowledge does not match the selected address.");

  property p_auto_inc;
    @(posedge core_clk) disable iff (!rst_n)
      wr_en |=> (rd_addr == $past(wr_addr) + 8'h01);
  endproperty
  a_auto_inc: assert property (p_auto_inc)
    else $error("Sub-address did not advance after a written byte.");
endmodule // vie_i2c_tgt

/* File: core/vie_top.sv */
// Purpose: Video enhancer core: capture, correction, gamma, output, PWM.
// Assumes: Pixel and bus inputs are synchronous to core_clk.
// Notes:   Registers are reached only through the two-wire target.
// Functional notes
// - Per-frame luma coefficient, applied next frame.
// - Luma correction with programmable strength.
// - Merge corrected chroma and luma into output.
// - Chroma correction with own strength.
// - Adjustable edge sharpening filter.
// - Nine-point piecewise-linear luma gamma.
// - Backlight duty manual or automatic.
// - Automatic duty recomputed once per frame.
// - Parameters, size and format from registers.
// - Clock and sync polarities independently selectable.
// - Edge select one samples falling; hsync level.
// - Vsync level zero means active low.
// - Windows from start and two-byte sizes.
// - Embedded-code input, both line standards.
// - Byte stream with separate sync inputs.
// - Target address 42h or 43h by select.
// - Sub-address increments per transferred byte.
// - Backlight output low during reset.
`include "vie_map.svh"
module vie_top #(
  parameter int PWM_DIV = 16
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       pixel_clock_in,
  input  wire logic [7:0] pixel_data_in,
  input  wire logic       hsync_in,
  input  wire logic       vsync_in,
  input  wire logic       target_address_select,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       sink_ready,
  output logic            pixel_clock_out,
  output logic [7:0]      pixel_data_out,
  output logic            hsync_out,
  output logic            vsync_out,
  output logic            backlight_pwm_out
);
  if (PWM_DIV < 1 || PWM_DIV > 256) begin : g_chk
    $error("PWM_DIV must lie between 1 and 256.");
  end

  vie_pkg::vie_core_t r_r, r_nxt;
  logic       rst_meta_r, rst_n;
  logic       wr_en;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  logic       pe, ha, va, sm, act, enh, luma, fs, push, pop, load;
  logic [1:0] wi;
  int         xi, rel, fxs, fxz, exs, exz, dl, y1, y2, y3, c1, g0, g1, sg;

  function automatic int vie_clamp(input int v);
    vie_clamp = (v < 0) ? 0 : ((v > `VIE_BYTE_MAX) ? `VIE_BYTE_MAX : v);
  endfunction

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  vie_i2c_tgt i_vie_i2c_tgt (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .addr_sel (target_address_select),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  always_comb begin
    unique case (rd_addr)
      `VIE_A_COEF:  rd_data = r_r.coef;
      `VIE_A_ADUTY: rd_data = r_r.duty;
      `VIE_A_STAT:  rd_data = {7'h00, r_r.ovr};
      `VIE_A_POL:   rd_data = r_r.sync_clock_polarity;
      default:
        rd_data = (rd_addr < 8'(`VIE_NREG)) ? r_r.regs[rd_addr[4:0]] : 8'h00;
    endcase
  end

  always_comb begin
    r_nxt = r_r;
    pe = r_r.sync_clock_polarity[`VIE_POL_CK] ? (r_r.pck_q && !pixel_clock_in)
                              : (!r_r.pck_q && pixel_clock_in);
    r_nxt.pck_q = pixel_clock_in;
    r_nxt.cap_v = pe;
    if (pe) begin
      r_nxt.cap_d  = pixel_data_in;
      r_nxt.cap_hs = hsync_in;
      r_nxt.cap_vs = vsync_in;
    end
    ha = r_r.cap_hs == r_r.sync_clock_polarity[`VIE_POL_HS];
    va = r_r.cap_vs == r_r.sync_clock_polarity[`VIE_POL_VS];
    sm  = r_r.regs[`VIE_A_FMT][`VIE_FMT_SYNC];
    fxs = int'({r_r.regs[`VIE_A_FXS + 1][3:0], r_r.regs[`VIE_A_FXS]});
    fxz = int'({r_r.regs[`VIE_A_FXZ + 1][3:0], r_r.regs[`VIE_A_FXZ]});
    exs = int'({r_r.regs[`VIE_A_EXS + 1][3:0], r_r.regs[`VIE_A_EXS]});
    exz = int'({r_r.regs[`VIE_A_EXZ + 1][3:0], r_r.regs[`VIE_A_EXZ]});
    xi  = int'(r_r.x);
    rel = xi - fxs;
    act = xi >= fxs && xi < fxs + 2 * fxz && (sm ? (!ha && !va)
                                                 : (!r_r.hb && !r_r.vb));
    enh = act && rel >= 2 * exs && rel < 2 * (exs + exz);
    luma = rel[0] ^ r_r.regs[`VIE_A_FMT][`VIE_FMT_YFST];
    dl = `VIE_MID - int'(r_r.coef);
    y1 = vie_clamp(int'(r_r.cap_d)
         + ((dl * int'(r_r.regs[`VIE_A_ESTR])) >>> `VIE_STR_SH));
    y2 = vie_clamp(y1 + (((y1 - int'(r_r.yp))
         * int'(r_r.regs[`VIE_A_EDGE])) >>> `VIE_STR_SH));
    sg = y2 >>> `VIE_GAM_SH;
    g0 = int'(r_r.regs[5'(int'(`VIE_A_GAM) + sg)]);
    g1 = int'(r_r.regs[5'(int'(`VIE_A_GAM) + sg + 1)]);
    y3 = g0 + (((g1 - g0) * (y2 & `VIE_GAM_FR)) >>> `VIE_GAM_SH);
    c1 = vie_clamp(int'(r_r.cap_d) + (((int'(r_r.cap_d) - `VIE_MID)
         * ((dl * int'(r_r.regs[`VIE_A_CSTR])) >>> `VIE_CG_SH))
         >>> `VIE_CG_SH));
    fs = 1'b0;
    if (r_r.cap_v) begin
      if (r_r.x != '1)
        r_nxt.x = r_r.x + 1'b1;
      if (sm) begin
        r_nxt.va_q = va;
        fs = va && !r_r.va_q;
        if (ha)
          r_nxt.x = '0;
      end else begin
        r_nxt.sy = 2'h0;
        if (r_r.cap_d == `VIE_CODE_FF)
          r_nxt.sy = 2'h1;
        else if (r_r.cap_d == 8'h00 && r_r.sy != 2'h0 && r_r.sy != 2'h3)
          r_nxt.sy = r_r.sy + 2'h1;
        if (r_r.sy == 2'h3) begin
          r_nxt.hb = r_r.cap_d[`VIE_CODE_H];
          r_nxt.vb = r_r.cap_d[`VIE_CODE_V];
          r_nxt.sy = 2'h0;
          r_nxt.x  = '0;
          fs = r_r.vb && !r_r.cap_d[`VIE_CODE_V];
        end
      end
      if (act && luma)
        r_nxt.avg = r_r.avg - (r_r.avg >> `VIE_AVG_SH)
                    + ({r_r.cap_d, 8'h00} >> `VIE_AVG_SH);
      if (enh && luma)
        r_nxt.yp = 8'(y1);
    end
    if (fs)
      r_nxt.coef = r_r.avg[15:8];
    if (!r_r.regs[`VIE_A_PWMC][`VIE_PWMC_AUTO])
      r_nxt.duty = r_r.regs[`VIE_A_DUTY];
    else if (fs)
      r_nxt.duty = r_r.avg[15:8];
    r_nxt.pdiv = r_r.pdiv + 8'h01;
    if (r_r.pdiv == 8'(PWM_DIV - 1)) begin
      r_nxt.pdiv = 8'h00;
      r_nxt.pcnt = r_r.pcnt + 8'h01;
    end
    r_nxt.pwm = r_r.pcnt < r_r.duty;
    pop  = r_r.bn != 2'h0 && sink_ready && r_r.oclk;
    push = r_r.s1_v && r_r.bn != `VIE_BUF_FULL;
    load = r_r.cap_v && (!r_r.s1_v || push);
    r_nxt.oclk = 1'b1;
    if (pop) begin
      {r_nxt.ohs, r_nxt.ovs, r_nxt.od} = r_r.bq[0];
      r_nxt.oclk = 1'b0;
      r_nxt.bq[0] = r_r.bq[1];
    end
    wi = r_r.bn - {1'b0, pop};
    if (push) begin
      r_nxt.bq[wi[0]] = {r_r.s1_hs, r_r.s1_vs, r_r.s1_d};
      r_nxt.s1_v = 1'b0;
    end
    r_nxt.bn = r_r.bn + {1'b0, push} - {1'b0, pop};
    if (wr_en && wr_addr == `VIE_A_STAT && wr_data[`VIE_STAT_OVR])
      r_nxt.ovr = 1'b0;
    if (load) begin
      r_nxt.s1_v  = 1'b1;
      r_nxt.s1_hs = sm ? ha : r_r.hb;
      r_nxt.s1_vs = sm ? va : r_r.vb;
      r_nxt.s1_d  = !enh ? r_r.cap_d : (luma ? 8'(y3) : 8'(c1));
    end else if (r_r.cap_v) begin
      r_nxt.ovr = 1'b1;
    end
    if (wr_en && wr_addr < 8'(`VIE_NREG))
      r_nxt.regs[wr_addr[4:0]] = wr_data;
    if (wr_en && wr_addr == `VIE_A_POL)
      r_nxt.sync_clock_polarity = wr_data;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r      <= '0;
      r_r.sync_clock_polarity  <= `VIE_POL_RST;
      r_r.oclk <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign pixel_clock_out   = r_r.oclk;
  assign pixel_data_out    = r_r.od;
  assign hsync_out         = r_r.ohs;
  assign vsync_out         = r_r.ovs;
  assign backlight_pwm_out = r_r.pwm;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_coef_take;
    fs |=> r_r.coef == $past(r_r.avg[15:8]);
  endproperty
  a_coef_take: assert property (p_coef_take)
    else $error("Coefficient not taken at frame start.");

  property p_coef_hold;
    !fs |=> $stable(r_r.coef);
  endproperty
  a_coef_hold: assert property (p_coef_hold)
    else $error("Coefficient changed inside a frame.");

  property p_pwm_rst;
    @(posedge core_clk) disable iff (1'b0)
      !rst_n |-> !backlight_pwm_out;
  endproperty
  a_pwm_rst: assert property (p_pwm_rst)
    else $error("Backlight output high during reset.");

  property p_manual;
    !r_r.regs[`VIE_A_PWMC][`VIE_PWMC_AUTO] ##1
      !r_r.regs[`VIE_A_PWMC][`VIE_PWMC_AUTO]
      |-> r_r.duty == $past(r_r.regs[`VIE_A_DUTY]);
  endproperty
  a_manual: assert property (p_manual)
    else $error("Manual duty not taken from register.");

  property p_duty_zero;
    r_r.duty == 8'h00 ##1 r_r.duty == 8'h00 |=> !backlight_pwm_out;
  endproperty
  a_duty_zero: assert property (p_duty_zero)
    else $error("Backlight high with zero duty.");

  property p_auto_frame;
    r_r.regs[`VIE_A_PWMC][`VIE_PWMC_AUTO] && !fs
      && $past(r_r.regs[`VIE_A_PWMC][`VIE_PWMC_AUTO]) |=> $stable(r_r.duty);
  endproperty
  a_auto_frame: assert property (p_auto_frame)
    else $error("Automatic duty changed outside frame start.");

  property p_edge;
    r_r.pck_q != pixel_clock_in
      |=> r_r.cap_v == $past(r_r.sync_clock_polarity[`VIE_POL_CK] == r_r.pck_q);
  endproperty
  a_edge: assert property (p_edge)
    else $error("Pixel captured on the wrong clock edge.");

  property p_vs_start;
    sm && r_r.cap_v && r_r.cap_vs == r_r.sync_clock_polarity[`VIE_POL_VS] && !r_r.va_q
      |-> fs;
  endproperty
  a_vs_start: assert property (p_vs_start)
    else $error("Vsync level not honoured for frame start.");

  property p_bypass;
    r_r.cap_v && !act && !r_r.s1_v |=> r_r.s1_d == $past(r_r.cap_d);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Byte outside the active window was altered.");

  property p_gam_knot;
    load && enh && luma && (y2 & `VIE_GAM_FR) == 0
      |=> r_r.s1_d == $past(8'(g0));
  endproperty
  a_gam_knot: assert property (p_gam_knot)
    else $error("Gamma knot value not reproduced.");
endmodule // vie_top

/* File: verif/vie_cam_model.sv */
// Purpose: Camera source model with counting bytes and sync pulses.
// Assumes: Pixel clock runs free at a quarter of core_clk.
// Notes:   Data changes on the edge opposite the sampling edge.
module vie_cam_model (
  input  wire logic  core_clk,
  input  wire logic  edge_sel,
  input  wire logic  hs_lvl,
  input  wire logic  vs_lvl,
  output logic       pck,
  output logic [7:0] dat,
  output logic       hs,
  output logic       vs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  logic [5:0] bx = 6'h00;
  logic [2:0] ln = 3'h0;
  initial begin
    pck = 1'b0;
    dat = 8'h00;
    hs  = 1'b1;
    vs  = 1'b1;
  end
  always @(posedge core_clk) begin
    #1;
    ph = ph + 2'h1;
    pck = ph[1];
    if (ph == {edge_sel, 1'b0}) begin
      dat = dat + 8'h01;
      bx  = bx + 6'h01;
      if (bx == 6'h00) begin
        ln = ln + 3'h1;
      end
      hs = (bx < 6'h08) ? hs_lvl : ~hs_lvl;
      vs = (ln == 3'h0) ? vs_lvl : ~vs_lvl;
    end
  end
endmodule // vie_cam_model

/* File: verif/vie_top_bench.sv */
// Purpose: Self-checking bench for the enhancer core.
// Assumes: PWM_DIV is 1; the camera runs at a quarter of core_clk.
// Notes:   Registers are reached through a bit-level two-wire master.
`include "vie_map.svh"
module vie_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       resetn   = 1'b0;
  logic       sel      = 1'b0;
  logic       scl      = 1'b1;
  logic       m_sda    = 1'b1;
  logic       ready    = 1'b1;
  logic       edge_sel = 1'b0;
  logic       hs_lvl   = 1'b0;
  logic       vs_lvl   = 1'b0;
  logic [6:0] dev      = 7'h42;
  logic       ack, pck, hs, vs, sda_out, sda_oe, pco, hso, vso, pwm;
  logic [7:0] pdi, pdo, a, b;
  logic [7:0] got_q[$];
  int         n_fail      = 0;
  int         comparisons = 0;
  int         cyc         = 0;
  int         n;
  wire        sda_w = m_sda & (sda_oe ? sda_out : 1'b1);

  vie_top #(.PWM_DIV(1)) i_vie_top (
    .core_clk(core_clk), .resetn(resetn), .pixel_clock_in(pck),
    .pixel_data_in(pdi), .hsync_in(hs), .vsync_in(vs),
    .target_address_select(sel), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .sink_ready(ready),
    .pixel_clock_out(pco), .pixel_data_out(pdo), .hsync_out(hso),
    .vsync_out(vso), .backlight_pwm_out(pwm)
  );
  vie_cam_model i_vie_cam_model (
    .core_clk(core_clk), .edge_sel(edge_sel), .hs_lvl(hs_lvl),
    .vs_lvl(vs_lvl), .pck(pck), .dat(pdi), .hs(hs), .vs(vs)
  );

  always #5 core_clk = ~core_clk;
  always @(posedge pco) got_q.push_back(pdo);
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic i2c_bit(input logic v, output logic r);
    m_sda = v;
    tick(3);
    scl = 1'b1;
    tick(3);
    r = sda_w;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic i2c_start();
    m_sda = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(3);
    m_sda = 1'b0;
    tick(3);
    scl = 1'b0;
    tick(3);
  endtask

  task automatic i2c_stop();
    m_sda = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(3);
    m_sda = 1'b1;
    tick(3);
  endtask

  task automatic i2c_tx(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_bit(v[i], r);
    i2c_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic i2c_rx(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, v[i]);
    i2c_bit(last, ack);
  endtask

  task automatic reg_wr(input logic [7:0] ad, d0, d1, input logic two);
    i2c_start();
    i2c_tx({dev, 1'b0});
    check(ack, 1'b1);
    i2c_tx(ad);
    i2c_tx(d0);
    if (two) i2c_tx(d1);
    i2c_stop();
  endtask

  task automatic reg_rd(input logic [7:0] ad, output logic [7:0] d0, d1);
    i2c_start();
    i2c_tx({dev, 1'b0});
    i2c_tx(ad);
    i2c_start();
    i2c_tx({dev, 1'b1});
    check(ack, 1'b1);
    i2c_rx(1'b0, d0);
    i2c_rx(1'b1, d1);
    i2c_stop();
  endtask

  task automatic t_regs();
    reg_rd(`VIE_A_POL, a, b);
    check(a, `VIE_POL_RST);
    reg_wr(`VIE_A_ESTR, 8'ha5, 8'h5a, 1'b1);
    reg_rd(`VIE_A_ESTR, a, b);
    check(a, 8'ha5);
    check(b, 8'h5a);
    reg_wr(8'h30, 8'hff, 8'hff, 1'b1);
    reg_rd(8'h30, a, b);
    check({a, b}, 16'h0000);
    reg_wr(`VIE_A_FXZ, 8'h1c, 8'h00, 1'b1);
    reg_wr(`VIE_A_FMT, 8'h01, 8'h00, 1'b0);
    reg_rd(`VIE_A_FMT, a, b);
    check(a, 8'h01);
  endtask

  task automatic t_addr();
    i2c_start();
    i2c_tx({7'h43, 1'b0});
    check(ack, 1'b0);
    i2c_stop();
    sel = 1'b1;
    dev = 7'h43;
    reg_wr(`VIE_A_CSTR, 8'h3c, 8'h00, 1'b0);
    reg_rd(`VIE_A_CSTR, a, b);
    check(a, 8'h3c);
    i2c_start();
    i2c_tx({7'h42, 1'b0});
    check(ack, 1'b0);
    i2c_stop();
    sel = 1'b0;
    dev = 7'h42;
  endtask

  task automatic set_pol(input logic [2:0] p);
    reg_wr(`VIE_A_POL, {5'h00, p}, 8'h00, 1'b0);
    edge_sel = p[0];
    hs_lvl   = p[1];
    vs_lvl   = p[2];
    reg_rd(`VIE_A_POL, a, b);
    check(a, {5'h00, p});
  endtask

  task automatic t_stream();
    tick(200);
    n = got_q.size();
    tick(200);
    check(got_q.size() >= n + 32, 1'b1);
    for (int k = n; k < n + 31; k++)
      check(got_q[k + 1], 8'(got_q[k] + 8'h01));
  endtask

  task automatic t_sync(input logic is_v);
    logic lv;
    lv = is_v ? vs_lvl : hs_lvl;
    for (int i = 0; i < 2600 && (is_v ? vs : hs) === lv; i++) tick(1);
    for (int i = 0; i < 2600 && (is_v ? vs : hs) !== lv; i++) tick(1);
    tick(20);
    check(is_v ? vso : hso, 1'b1);
    for (int i = 0; i < 2600 && (is_v ? vs : hs) === lv; i++) tick(1);
    tick(20);
    check(is_v ? vso : hso, 1'b0);
  endtask

  task automatic t_stall();
    ready = 1'b0;
    tick(40);
    n = got_q.size();
    tick(100);
    check(got_q.size() == n, 1'b1);
    reg_rd(`VIE_A_STAT, a, b);
    check(a[0], 1'b1);
    ready = 1'b1;
    tick(40);
    check(got_q[n], 8'(got_q[n - 1] + 8'h01));
    check(got_q[n + 1], 8'(got_q[n] + 8'h01));
    reg_wr(`VIE_A_STAT, 8'h01, 8'h00, 1'b0);
    reg_rd(`VIE_A_STAT, a, b);
    check(a[0], 1'b0);
  endtask

  task automatic pwm_count(input logic [15:0] exp);
    logic [15:0] hi;
    hi = 16'h0000;
    tick(300);
    repeat (512) begin
      tick(1);
      hi = hi + {15'h0000, pwm};
    end
    check(hi, exp);
  endtask

  task automatic t_pwm();
    reg_wr(`VIE_A_PWMC, 8'h00, 8'h40, 1'b1);
    pwm_count(16'h0080);
    reg_rd(`VIE_A_ADUTY, a, b);
    check(a, 8'h40);
    reg_wr(`VIE_A_DUTY, 8'h00, 8'h00, 1'b0);
    pwm_count(16'h0000);
    reg_wr(`VIE_A_DUTY, 8'hff, 8'h00, 1'b0);
    for (int i = 0; i < 300 && pwm !== 1'b1; i++) tick(1);
    resetn = 1'b0;
    tick(1);
    check({pwm, pco, pdo}, 10'h100);
    tick(3);
    resetn = 1'b1;
    tick(4);
    reg_rd(`VIE_A_ESTR, a, b);
    check({a, b}, 16'h0000);
  endtask

  initial begin
    tick(2);
    check({pwm, pco, pdo}, 10'h100);
    tick(2);
    resetn = 1'b1;
    tick(4);
    t_regs();
    t_addr();
    set_pol(3'b000);
    t_stream();
    t_sync(1'b0);
    t_sync(1'b1);
    set_pol(3'b111);
    t_stream();
    t_sync(1'b0);
    t_sync(1'b1);
    t_stall();
    t_pwm();
    end_of_test();
  end
endmodule // vie_top_bench
